// >>> test/rsc_board.sv
`timescale 1ns/1ns
module rsc_board (
  // clock and bench requests
  input wire logic clk_i,
  input wire logic rst_req_i,
  input wire logic [4:0] strap_i,
  input wire logic host_cs_n_i,
  // device drive on the shared pin
  input wire logic dev_miso_i,
  input wire logic dev_miso_oe_i,
  // pins seen by the device
  output logic chip_reset_low_o,
  output logic test_o,
  output logic ac0_o,
  output logic ac1_o,
  output logic if0_o,
  output logic if1_o
);
  logic [3:0] hold_r;
  logic straps_on;

  initial begin
    chip_reset_low_o = 1'b0;
    hold_r = 4'h6;
  end

  // reset driver holds the pin low while asked, then keeps straps a while
  always @(posedge clk_i) begin
    chip_reset_low_o <= !rst_req_i;
    hold_r <= rst_req_i ? 4'h6 : ((hold_r != 4'h0) ? hold_r - 4'h1 : 4'h0);
  end

  assign straps_on = !chip_reset_low_o || (hold_r != 4'h0);
  // resistors are static; test strap low unless the bench asks
  assign test_o = strap_i[rsc_pkg::STRAP_TEST];
  assign ac0_o = strap_i[rsc_pkg::STRAP_AC0];
  assign ac1_o = strap_i[rsc_pkg::STRAP_AC1];
  // host owns chip select once the strap window is over
  assign if0_o = straps_on ? strap_i[rsc_pkg::STRAP_IF0] : host_cs_n_i;
  // undriven line falls back to its strap resistor level
  assign if1_o = dev_miso_oe_i ? dev_miso_i : strap_i[rsc_pkg::STRAP_IF1];
endmodule // rsc_board

// >>> test/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic clk_i, rst_n_i, rst_req, host_cs_n, spi_miso, spi_miso_oe, reg_wr, reg_rd, ce, cs_pin, cs_oe;
  bit hung = 1'b0;
  logic [4:0] strap;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, rd;
  logic p_rst, p_test, p_ac0, p_ac1, p_if0, p_if1;
  logic miso_pin, miso_oe, ref_a_en, xtal_en, ready, cs_n, ser_pin, test_mode;
  rsc_pkg::rsc_host_cfg_t host_cfg;
  rsc_pkg::rsc_out_cfg_t out_cfg;
  logic [31:0] reg_rdata;
  int num_errors = 0;
  int samples_checked = 0;

  rsc_board board (.clk_i(clk_i), .rst_req_i(rst_req), .strap_i(strap), .host_cs_n_i(host_cs_n),
    .dev_miso_i(miso_pin), .dev_miso_oe_i(miso_oe), .chip_reset_low_o(p_rst), .test_o(p_test),
    .ac0_o(p_ac0), .ac1_o(p_ac1), .if0_o(p_if0), .if1_o(p_if1));

  rsc_strap_loader DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .chip_reset_low_i(p_rst),
    .test_strap_i(p_test), .auto_cfg_sel_bit0_i(p_ac0), .auto_cfg_sel_bit1_i(p_ac1),
    .iface_sel0_or_chip_select_i(p_if0), .iface_sel0_or_chip_select_o(cs_pin),
    .iface_sel0_or_chip_select_oe_o(cs_oe), .iface_sel1_or_serial_out_i(p_if1),
    .iface_sel1_or_serial_out_o(miso_pin), .iface_sel1_or_serial_out_oe_o(miso_oe),
    .ref_pin_a_se_en_o(ref_a_en), .ref_xtal_drv_en_o(xtal_en), .ready_o(ready),
    .spi_miso_i(spi_miso), .spi_miso_oe_i(spi_miso_oe), .spi_cs_n_o(cs_n), .serial_out_pin_o(ser_pin),
    .test_mode_o(test_mode), .host_cfg_o(host_cfg), .out_cfg_o(out_cfg), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = !clk_i;
  end

  task automatic summarize();
    if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_i);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_i);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // own decode tables, kept apart from the design's helpers
  function automatic logic [31:0] exp_host(input logic [1:0] c);
    return (c == 2'h3) ? 32'h0000_0080 : {25'h0, 5'h1b, c};
  endfunction

  function automatic logic [31:0] exp_out(input logic [1:0] c);
    case (c)
      2'h0: return 32'h0000_0011;
      2'h1: return 32'h0000_0019;
      2'h2: return 32'h0000_0015;
      default: return 32'h0000_001b;
    endcase
  endfunction

  task automatic do_capture(input logic [4:0] s);
    int n;
    @(posedge clk_i);
    strap <= s;
    rst_req <= 1'b1;
    cyc(5);
    chk(ready, 1'b0);
    chk(xtal_en, 1'b1);
    @(posedge clk_i);
    rst_req <= 1'b0;
    n = 0;
    while (ready !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    if (n >= 100) begin
      num_errors++;
      hung = 1'b1;
      return;
    end
    chk(ready, 1'b1);
    chk(test_mode, s[4]);
    chk(host_cfg, exp_host(s[1:0]));
    chk(out_cfg, exp_out(s[3:2]));
    chk(xtal_en, 1'b1);
    chk(ref_a_en, 1'b0);
    rd_reg(rsc_pkg::REG_STRAP_STATUS, rd);
    chk(rd, {27'h0, s});
  endtask

  task automatic sc_all_codes();
    for (int i = 0; i < 4; i++) begin
      do_capture({1'b0, 2'(i), 2'(i)});
    end
    do_capture(5'h19);
  endtask

  task automatic sc_shared_pins();
    do_capture(5'h03);
    @(posedge clk_i);
    host_cs_n <= 1'b0;
    spi_miso <= 1'b0;
    spi_miso_oe <= 1'b1;
    cyc(4);
    chk(cs_n, 1'b0);
    chk(miso_oe, 1'b1);
    chk(ser_pin, 1'b0);
    chk({cs_oe, cs_pin}, 2'h1);
    rd_reg(rsc_pkg::REG_STRAP_STATUS, rd);
    chk(rd, 32'h0000_0003);
    rd_reg(rsc_pkg::REG_DEV_STATE, rd);
    chk(rd, 32'h0000_0001);
    chk(host_cfg, exp_host(2'h3));
    @(posedge clk_i);
    host_cs_n <= 1'b1;
    spi_miso_oe <= 1'b0;
  endtask

  task automatic sc_ref_select();
    wr_reg(rsc_pkg::REG_REF_SELECT, 32'h0000_0002);
    cyc(2);
    chk(ref_a_en, 1'b1);
    chk(xtal_en, 1'b0);
    rd_reg(rsc_pkg::REG_REF_SELECT, rd);
    chk(rd, 32'h0000_0002);
    wr_reg(rsc_pkg::REG_REF_SELECT, 32'h0000_0003);
    cyc(2);
    chk({ref_a_en, xtal_en}, 2'h0);
    wr_reg(rsc_pkg::REG_REF_SELECT, 32'h0000_0001);
    cyc(2);
    chk({ref_a_en, xtal_en}, 2'h1);
    // read-only status must ignore writes; unmapped space reads as zero
    wr_reg(rsc_pkg::REG_STRAP_STATUS, 32'h0000_001f);
    rd_reg(rsc_pkg::REG_STRAP_STATUS, rd);
    chk(rd, 32'h0000_0003);
    rd_reg(8'h0c, rd);
    chk(rd, 32'h0000_0000);
    wr_reg(rsc_pkg::REG_REF_SELECT, 32'h0000_0002);
    do_capture(5'h06);
  endtask

  // a write while the enable is low must not land
  task automatic sc_clock_enable();
    @(posedge clk_i);
    ce <= 1'b0;
    wr_reg(rsc_pkg::REG_REF_SELECT, 32'h0000_0002);
    cyc(2);
    chk({ref_a_en, xtal_en}, 2'h1);
    chk(ready, 1'b1);
    @(posedge clk_i);
    ce <= 1'b1;
    rd_reg(rsc_pkg::REG_REF_SELECT, rd);
    chk(rd, 32'h0000_0001);
  endtask

  initial begin
    rst_n_i = 1'b0;
    ce = 1'b1;
    rst_req = 1'b1;
    strap = 5'h00;
    host_cs_n = 1'b1;
    spi_miso = 1'b0;
    spi_miso_oe = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    sc_all_codes();
    if (!hung) sc_shared_pins();
    if (!hung) sc_ref_select();
    if (!hung) sc_clock_enable();
    summarize();
  end
endmodule // testbench

// >>> verilog/rsc_pkg.sv
package rsc_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int SETTLE_NS = 100;
  localparam int SETTLE_CYC_INT = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] SETTLE_CYC = CNT_W'(SETTLE_CYC_INT);
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

  // strap vector layout
  localparam int STRAP_W = 5;
  localparam int STRAP_IF0 = 0;
  localparam int STRAP_IF1 = 1;
  localparam int STRAP_AC0 = 2;
  localparam int STRAP_AC1 = 3;
  localparam int STRAP_TEST = 4;
  localparam int SYNC_W = STRAP_W + 1;
  localparam int SYNC_RST = STRAP_W;

  // register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_STRAP_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_REF_SELECT = 8'h04;
  localparam logic [ADDR_W-1:0] REG_DEV_STATE = 8'h08;
  localparam int STATE_READY_BIT = 0;
  localparam int STATE_SETTLE_BIT = 1;
  localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

  // reference input select
  localparam int REF_SEL_W = 2;
  localparam logic [REF_SEL_W-1:0] REF_SEL_OFF = 2'h0;
  localparam logic [REF_SEL_W-1:0] REF_SEL_XTAL = 2'h1;
  localparam logic [REF_SEL_W-1:0] REF_SEL_OSC = 2'h2;
  localparam logic [REF_SEL_W-1:0] REF_SEL_RESET = REF_SEL_XTAL;

  // host interface codes
  localparam logic [1:0] IFACE_SPI = 2'h3;
  localparam int I2C_ADDR_W = 7;
  localparam logic [4:0] I2C_ADDR_BASE = 5'h1b;

  // auto configuration codes
  localparam logic [1:0] AC_CFG0 = 2'h0;
  localparam logic [1:0] AC_CFG1 = 2'h1;
  localparam logic [1:0] AC_CFG2 = 2'h2;
  localparam logic [1:0] AC_CFG3 = 2'h3;

  typedef struct packed {
    logic test;
    logic [1:0] auto_cfg;
    logic [1:0] iface;
  } rsc_strap_t;

  typedef struct packed {
    logic out1_cml_en;
    logic out2_cml_en;
    logic out2_hstl_en;
    logic out3_cmos_en;
    logic ref_xtal_25m;
  } rsc_out_cfg_t;

  typedef struct packed {
    logic spi_mode;
    logic [I2C_ADDR_W-1:0] i2c_addr;
  } rsc_host_cfg_t;

  typedef enum logic [1:0] {ST_IN_RESET, ST_SETTLE, ST_READY} rsc_state_t;

  function automatic rsc_host_cfg_t decode_host(input logic [1:0] code);
    rsc_host_cfg_t h;
    h.spi_mode = (code == IFACE_SPI);
    h.i2c_addr = h.spi_mode ? 7'h00 : {I2C_ADDR_BASE, code};
    return h;
  endfunction

  function automatic rsc_out_cfg_t decode_auto(input logic [1:0] code);
    rsc_out_cfg_t c;
    c = '0;
    c.out1_cml_en = 1'h1;
    c.ref_xtal_25m = 1'h1;
    unique case (code)
      AC_CFG0: c.out2_cml_en = 1'h0;
      AC_CFG1: c.out2_cml_en = 1'h1;
      AC_CFG2: c.out2_hstl_en = 1'h1;
      AC_CFG3: begin
        c.out2_cml_en = 1'h1;
        c.out3_cmos_en = 1'h1;
      end
    endcase
    return c;
  endfunction

endpackage

// >>> verilog/rsc_strap_loader.sv
`timescale 1ns/1ns
module rsc_strap_loader (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // strap and reset pins
  input wire logic chip_reset_low_i,
  input wire logic test_strap_i,
  input wire logic auto_cfg_sel_bit0_i,
  input wire logic auto_cfg_sel_bit1_i,
  input wire logic iface_sel0_or_chip_select_i,
  output logic iface_sel0_or_chip_select_o,
  output logic iface_sel0_or_chip_select_oe_o,
  input wire logic iface_sel1_or_serial_out_i,
  output logic iface_sel1_or_serial_out_o,
  output logic iface_sel1_or_serial_out_oe_o,
  // reference and status pins
  output logic ref_pin_a_se_en_o,
  output logic ref_xtal_drv_en_o,
  output logic ready_o,
  // serial engine side
  input wire logic spi_miso_i,
  input wire logic spi_miso_oe_i,
  output logic spi_cs_n_o,
  output logic serial_out_pin_o,
  // configuration to the device core
  output logic test_mode_o,
  output rsc_pkg::rsc_host_cfg_t host_cfg_o,
  output rsc_pkg::rsc_out_cfg_t out_cfg_o,
  // register port
  input wire logic [rsc_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [rsc_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [rsc_pkg::DATA_W-1:0] reg_rdata_o
);

  logic [rsc_pkg::SYNC_W-1:0] pins_raw;
  logic [rsc_pkg::SYNC_W-1:0] pins_s;
  logic pin_rst;
  logic pin_rise;
  rsc_pkg::rsc_strap_t straps_s;

  rsc_pkg::rsc_state_t st_r;
  rsc_pkg::rsc_state_t st_nxt;
  logic [rsc_pkg::CNT_W-1:0] cnt_r;
  logic [rsc_pkg::CNT_W-1:0] cnt_nxt;
  logic pin_rst_d_r;
  logic pin_rst_d_nxt;
  rsc_pkg::rsc_strap_t strap_r;
  rsc_pkg::rsc_strap_t strap_nxt;
  logic [rsc_pkg::REF_SEL_W-1:0] ref_sel_r;
  logic [rsc_pkg::REF_SEL_W-1:0] ref_sel_nxt;
  logic ready_r;
  logic ready_nxt;
  rsc_pkg::rsc_host_cfg_t host_cfg_r;
  rsc_pkg::rsc_host_cfg_t host_cfg_nxt;
  rsc_pkg::rsc_out_cfg_t out_cfg_r;
  rsc_pkg::rsc_out_cfg_t out_cfg_nxt;
  logic ref_se_r;
  logic ref_se_nxt;
  logic ref_xtal_r;
  logic ref_xtal_nxt;
  logic [rsc_pkg::DATA_W-1:0] rdata_r;
  logic [rsc_pkg::DATA_W-1:0] rdata_nxt;
  logic [rsc_pkg::DATA_W-1:0] dev_state_word;

  // reset pin and straps share one synchroniser so they line up to the cycle
  assign pins_raw[rsc_pkg::SYNC_RST] = chip_reset_low_i;
  assign pins_raw[rsc_pkg::STRAP_TEST] = test_strap_i;
  assign pins_raw[rsc_pkg::STRAP_AC1] = auto_cfg_sel_bit1_i;
  assign pins_raw[rsc_pkg::STRAP_AC0] = auto_cfg_sel_bit0_i;
  assign pins_raw[rsc_pkg::STRAP_IF1] = iface_sel1_or_serial_out_i;
  assign pins_raw[rsc_pkg::STRAP_IF0] = iface_sel0_or_chip_select_i;

  rsc_sync2 #(
    .W(rsc_pkg::SYNC_W)
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .d_i(pins_raw),
    .q_o(pins_s)
  );

  assign pin_rst = pins_s[rsc_pkg::SYNC_RST];
  assign straps_s = rsc_pkg::rsc_strap_t'(pins_s[rsc_pkg::STRAP_W-1:0]);
  assign pin_rise = pin_rst && !pin_rst_d_r;

  // configuration state
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    pin_rst_d_nxt = pin_rst;
    strap_nxt = strap_r;
    ref_sel_nxt = ref_sel_r;
    if (!pin_rst) begin
      // held at defaults for as long as the pin stays low
      st_nxt = rsc_pkg::ST_IN_RESET;
      cnt_nxt = rsc_pkg::CNT_ZERO;
      strap_nxt = '0;
      ref_sel_nxt = rsc_pkg::REF_SEL_RESET;
    end else begin
      unique case (st_r)
        rsc_pkg::ST_IN_RESET: begin
          if (pin_rise) begin
            strap_nxt = straps_s;
            ref_sel_nxt = rsc_pkg::REF_SEL_XTAL;
            cnt_nxt = rsc_pkg::SETTLE_CYC - rsc_pkg::CNT_ONE;
            st_nxt = rsc_pkg::ST_SETTLE;
          end
        end
        rsc_pkg::ST_SETTLE: begin
          if (cnt_r == rsc_pkg::CNT_ZERO) begin
            st_nxt = rsc_pkg::ST_READY;
          end else begin
            cnt_nxt = cnt_r - rsc_pkg::CNT_ONE;
          end
        end
        rsc_pkg::ST_READY: begin
          st_nxt = rsc_pkg::ST_READY;
        end
      endcase
      // software may override the reference choice once configured
      if (reg_wr_i && (reg_addr_i == rsc_pkg::REG_REF_SELECT) && (st_r != rsc_pkg::ST_IN_RESET)) begin
        ref_sel_nxt = reg_wdata_i[rsc_pkg::REF_SEL_W-1:0];
      end
    end
    ready_nxt = (st_nxt == rsc_pkg::ST_READY);
    host_cfg_nxt = rsc_pkg::decode_host(strap_nxt.iface);
    out_cfg_nxt = rsc_pkg::decode_auto(strap_nxt.auto_cfg);
    ref_se_nxt = (ref_sel_nxt == rsc_pkg::REF_SEL_OSC);
    ref_xtal_nxt = (ref_sel_nxt == rsc_pkg::REF_SEL_XTAL);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r <= rsc_pkg::ST_IN_RESET;
      cnt_r <= rsc_pkg::CNT_ZERO;
      pin_rst_d_r <= 1'h0;
      strap_r <= '0;
      ref_sel_r <= rsc_pkg::REF_SEL_RESET;
      ready_r <= 1'h0;
      host_cfg_r <= '0;
      out_cfg_r <= '0;
      ref_se_r <= 1'h0;
      // matches the crystal default of the select register so both agree from the first edge
      ref_xtal_r <= 1'h1;
    end else if (ce_i) begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      pin_rst_d_r <= pin_rst_d_nxt;
      strap_r <= strap_nxt;
      ref_sel_r <= ref_sel_nxt;
      ready_r <= ready_nxt;
      host_cfg_r <= host_cfg_nxt;
      out_cfg_r <= out_cfg_nxt;
      ref_se_r <= ref_se_nxt;
      ref_xtal_r <= ref_xtal_nxt;
    end
  end

  // register reads, answer only in the cycle after the strobe
  always_comb begin
    dev_state_word = rsc_pkg::RDATA_ZERO;
    dev_state_word[rsc_pkg::STATE_READY_BIT] = ready_r;
    dev_state_word[rsc_pkg::STATE_SETTLE_BIT] = (st_r == rsc_pkg::ST_SETTLE);
    rdata_nxt = rsc_pkg::RDATA_ZERO;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        rsc_pkg::REG_STRAP_STATUS: rdata_nxt[rsc_pkg::STRAP_W-1:0] = strap_r;
        rsc_pkg::REG_REF_SELECT: rdata_nxt[rsc_pkg::REF_SEL_W-1:0] = ref_sel_r;
        rsc_pkg::REG_DEV_STATE: rdata_nxt = dev_state_word;
        default: rdata_nxt = rsc_pkg::RDATA_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_r <= rsc_pkg::RDATA_ZERO;
    end else if (ce_i) begin
      rdata_r <= rdata_nxt;
    end
  end

  // pin hand-over: straps stay undriven until the device is ready
  assign iface_sel0_or_chip_select_o = 1'h1;
  assign iface_sel0_or_chip_select_oe_o = 1'h0;
  assign iface_sel1_or_serial_out_o = spi_miso_i;
  assign iface_sel1_or_serial_out_oe_o = ready_r && host_cfg_r.spi_mode && spi_miso_oe_i;
  assign spi_cs_n_o = (ready_r && host_cfg_r.spi_mode) ? straps_s.iface[0] : 1'h1;
  assign serial_out_pin_o = straps_s.iface[1];

  assign ref_pin_a_se_en_o = ref_se_r;
  assign ref_xtal_drv_en_o = ref_xtal_r;
  assign ready_o = ready_r;
  assign test_mode_o = strap_r.test;
  assign host_cfg_o = host_cfg_r;
  assign out_cfg_o = out_cfg_r;
  assign reg_rdata_o = rdata_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_release;
    ce_i && pin_rise;
  endsequence

  sequence s_held_low;
    !ready_o [*8];
  endsequence

  a_strap_capture: assert property (s_release |=> strap_r == $past(straps_s))
    else $error("straps not captured at reset release");

  a_strap_readback: assert property (ce_i && reg_rd_i && reg_addr_i == rsc_pkg::REG_STRAP_STATUS
      |=> reg_rdata_o == {27'h0, $past(strap_r)})
    else $error("strap status read does not match latch");

  a_strap_stable: assert property (ce_i && pin_rst && !pin_rise |=> $stable(strap_r))
    else $error("latched straps changed without reset");

  a_pin_reset_clear: assert property (ce_i && !pin_rst |=> !ready_o && strap_r == '0 && ref_xtal_drv_en_o)
    else $error("pin reset did not restore defaults");

  a_ready_late: assert property (s_release |=> s_held_low)
    else $error("ready rose too early after release");

  a_ready_rise: assert property (ce_i && pin_rst && st_r == rsc_pkg::ST_SETTLE && cnt_r == rsc_pkg::CNT_ZERO
      |=> ready_o)
    else $error("ready did not rise after settle");

  a_test_follow: assert property (s_release ##1 ce_i && pin_rst |=> test_mode_o == $past(straps_s.test, 2))
    else $error("test mode does not follow test strap");

  a_host_decode: assert property (ready_o |-> host_cfg_o == rsc_pkg::decode_host(strap_r.iface))
    else $error("host interface decode wrong");

  a_auto_decode: assert property (ready_o |-> out_cfg_o == rsc_pkg::decode_auto(strap_r.auto_cfg)
      && out_cfg_o.ref_xtal_25m)
    else $error("auto configuration decode wrong");

  a_ref_default: assert property (s_release |=> ref_sel_r == rsc_pkg::REF_SEL_XTAL && ref_xtal_drv_en_o)
    else $error("crystal not selected after release");

  a_ref_osc: assert property (ref_sel_r == rsc_pkg::REF_SEL_OSC |-> ref_pin_a_se_en_o && !ref_xtal_drv_en_o)
    else $error("oscillator select not applied");

  a_ref_xtal: assert property (ref_sel_r == rsc_pkg::REF_SEL_XTAL |-> ref_xtal_drv_en_o && !ref_pin_a_se_en_o)
    else $error("crystal select not applied");

  a_pin_handover: assert property (!ready_o |-> !iface_sel1_or_serial_out_oe_o && spi_cs_n_o)
    else $error("strap pin driven before ready");

endmodule // rsc_strap_loader

// >>> verilog/rsc_sync2.sv
`timescale 1ns/1ns
module rsc_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // first stage feeds only the second stage
  always_comb begin
    meta_nxt = d_i;
    q_nxt = meta_r;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      q_r <= '0;
    end else if (ce_i) begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
    end
  end

  assign q_o = q_r;

endmodule // rsc_sync2
